// ===== touch_key_map.svh
// Purpose: Constants for the touch key command handler
// Assumes: 200 MHz core clock
// Notes: CRC polynomial and seed are plain defaults
`ifndef TOUCH_KEY_MAP_SVH
`define TOUCH_KEY_MAP_SVH
`define CMD_SLEEP 8'h16
`define CLASS_NONE 2'h0
`define CLASS_DATA 2'h1
`define CLASS_STATUS 2'h2
`define CLASS_CAL 2'h3
`define KEY_LAST 6'h2F
`define SETUP_LEN 9'h15E
`define CRC_POLY 16'h1021
`define CRC_INIT 16'h0000
`define CAL_WINDOW_MS 110
`define CLK_KHZ 200000
`define DATA_LEN 3'h5
`define ONE_LEN 3'h1
`define ST_GAIN_FAULT 4
`define ST_DETECT 3
`define ST_BELOW_LIMIT 2
`define ST_CALIBRATING 1
`define ST_CAL_FAILED 0
`endif

// ===== touch_key_pkg.sv
// Purpose: Types shared by the touch key command handler
// Assumes: Nothing beyond the map header
// Notes: Key index is six bits, valid range 0 to 47
package touch_key_pkg;
	typedef logic [5:0] key_idx_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SEND = 2'b10
	} resp_state_t;
	typedef enum logic [1:0] {
		RESP_ACK = 2'b00,
		RESP_DATA = 2'b01,
		RESP_STATUS = 2'b10
	} resp_kind_t;
endpackage

// ===== crc_if.sv
// Purpose: Carries one CRC step between handler and engine
// Assumes: Combinational engine
// Notes: One byte per step
interface crc_if;
	logic [15:0] crc;
	logic [7:0] data;
	logic [15:0] next;
	modport engine(input crc, input data, output next);
	modport user(output crc, output data, input next);
endinterface

// ===== crc16_step.sv
// Purpose: One byte of CRC-16, most significant bit first
// Assumes: Polynomial from the map header
// Notes: Purely combinational
`include "touch_key_map.svh"
module crc16_step (
	crc_if.engine port
);
	always_comb begin
		logic [15:0] c;
		c = port.crc;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ port.data[i]) begin
				c = {c[14:0], 1'b0} ^ `CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		port.next = c;
	end
endmodule

// ===== touch_key_command_handler.sv
// Purpose: Host byte command handler for a 48-key touch matrix
// Assumes: Byte stream already deserialised; key data on same clock
// Notes: Commands arriving during a reply are held off by rx_ready
`include "touch_key_map.svh"
// What this block does
// - Sleep command: sleep at scan end if allowed
// - Sleep acknowledged with inverted command byte
// - Asleep: wake input triggers scan, then sleep
// - Any other valid command cancels sleep
// - Data command returns signal, reference, integrator
// - Two-byte values go low byte first
// - Data and status replies end with CRC-16
// - Status command returns one key status byte
// - Status bits 7-5 zero, gain fault, detect
// - Status bits below-limit, calibrating, calibration failed
// - Calibrate only after two identical sends within 110ms
// - Calibration runs in Run mode, own timeslot
// - Scheduled calibration acknowledged with inverted byte
// - Setup block of 350 bytes stored in array
module touch_key_command_handler #(
	parameter int unsigned CAL_WINDOW_CYC = `CAL_WINDOW_MS * `CLK_KHZ
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	input wire logic tx_ready,
	output touch_key_pkg::key_idx_t key_sel,
	input wire logic [15:0] key_signal,
	input wire logic [15:0] key_reference,
	input wire logic [7:0] normal_integrator_count,
	input wire logic key_gain_fault_test,
	input wire logic key_detect,
	input wire logic key_below_lower_signal_limit,
	input wire logic key_calibrating,
	input wire logic key_cal_failed,
	input wire logic sleep_enable_cfg,
	input wire logic key_activity,
	input wire logic scan_end,
	input wire logic wake_pin,
	output logic sleep_active,
	output logic wake_scan,
	input wire logic run_mode,
	input wire logic slot_valid,
	input wire touch_key_pkg::key_idx_t slot_key,
	output logic cal_start,
	output touch_key_pkg::key_idx_t cal_key,
	input wire logic setup_valid,
	input wire logic [7:0] setup_byte,
	output logic nv_wr,
	output logic [8:0] nv_addr,
	output logic [7:0] nv_data,
	output logic setup_full,
	output logic reload_pending
);
	import touch_key_pkg::*;

	localparam logic [24:0] CAL_LIMIT = 25'(CAL_WINDOW_CYC);

	crc_if crc_bus ();
	crc16_step u_crc (
		.port(crc_bus.engine)
	);

	resp_state_t state, next_state;
	resp_kind_t kind, next_kind;
	logic [7:0] cmd, next_cmd;
	logic [7:0] resp [5];
	logic [7:0] next_resp [5];
	logic [2:0] dlen, next_dlen, pos, next_pos;
	logic with_crc, next_with_crc;
	logic [15:0] crc, next_crc;
	logic [7:0] next_tx_byte;
	key_idx_t next_key_sel;
	logic sleep_armed, next_sleep_armed, next_sleep_active, next_wake_scan;
	logic [2:0] wake_sync;
	logic wake_lvl, next_wake_lvl;
	logic cal_arm, next_cal_arm, cal_pend, next_cal_pend, next_cal_start;
	key_idx_t arm_key, next_arm_key, next_cal_key;
	logic [24:0] cal_timer, next_cal_timer;
	logic [8:0] setup_count, next_setup_count;
	logic next_nv_wr, next_setup_full, next_reload_pending;
	logic [8:0] next_nv_addr;
	logic [7:0] next_nv_data;
	logic rx_take, tx_take, idx_ok, is_sleep, is_keyed, wake_rise;
	logic [2:0] last_pos, npos;
	logic [1:0] cls;

	assign rx_ready = (state == ST_IDLE);
	assign tx_valid = (state == ST_SEND);
	assign rx_take = rx_valid && rx_ready;
	assign tx_take = tx_valid && tx_ready;
	assign cls = rx_byte[7:6];
	assign idx_ok = (rx_byte[5:0] <= `KEY_LAST);
	assign is_sleep = (rx_byte == `CMD_SLEEP);
	assign is_keyed = (cls != `CLASS_NONE) && idx_ok;
	assign last_pos = with_crc ? dlen + 3'h1 : dlen - 3'h1;
	assign npos = pos + 3'h1;
	// Change counts once second and third stage agree
	assign wake_rise = (wake_sync[1] == wake_sync[2]) && wake_sync[2]
		&& !wake_lvl;
	// Command byte is folded in at accept, replies while sending
	assign crc_bus.crc = (state == ST_SEND) ? crc : `CRC_INIT;
	assign crc_bus.data = (state == ST_SEND) ? tx_byte : rx_byte;

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_cmd = cmd;
		next_resp = resp;
		next_dlen = dlen;
		next_pos = pos;
		next_with_crc = with_crc;
		next_crc = crc;
		next_tx_byte = tx_byte;
		next_key_sel = key_sel;
		next_sleep_armed = sleep_armed;
		next_sleep_active = sleep_active;
		next_wake_scan = 1'b0;
		next_wake_lvl = wake_lvl;
		next_cal_arm = cal_arm;
		next_arm_key = arm_key;
		next_cal_timer = cal_timer;
		next_cal_pend = cal_pend;
		next_cal_key = cal_key;
		next_cal_start = 1'b0;
		next_setup_count = setup_count;
		next_nv_wr = 1'b0;
		next_nv_addr = nv_addr;
		next_nv_data = nv_data;
		next_setup_full = setup_full;
		next_reload_pending = reload_pending;

		// Double-send window; expiry drops the first send
		if (cal_arm) begin
			if (cal_timer >= CAL_LIMIT) begin
				next_cal_arm = 1'b0;
			end else begin
				next_cal_timer = cal_timer + 25'h1;
			end
		end

		// Sleep sequencing
		if (wake_sync[1] == wake_sync[2]) begin
			next_wake_lvl = wake_sync[2];
		end
		if (sleep_active && wake_rise) begin
			next_sleep_active = 1'b0;
			next_wake_scan = 1'b1;
		end else if (!sleep_active && scan_end && sleep_armed
			&& sleep_enable_cfg && !key_activity) begin
			next_sleep_active = 1'b1;
		end

		// Calibration waits for its own key's timeslot
		if (cal_pend && slot_valid && slot_key == cal_key) begin
			next_cal_pend = 1'b0;
			next_cal_start = 1'b1;
		end

		unique case (state)
			ST_IDLE: begin
				if (rx_take) begin
					next_cmd = rx_byte;
					next_key_sel = rx_byte[5:0];
					next_crc = crc_bus.next;
					// Anything but a matching repeat breaks the pair
					if (!(cls == `CLASS_CAL && idx_ok)) begin
						next_cal_arm = 1'b0;
					end
					if (is_sleep) begin
						next_sleep_armed = 1'b1;
						next_kind = RESP_ACK;
						next_state = ST_LOAD;
					end else if (is_keyed) begin
						next_sleep_armed = 1'b0;
						next_sleep_active = 1'b0;
						if (cls == `CLASS_DATA) begin
							next_kind = RESP_DATA;
							next_state = ST_LOAD;
						end else if (cls == `CLASS_STATUS) begin
							next_kind = RESP_STATUS;
							next_state = ST_LOAD;
						end else if (!run_mode) begin
							next_cal_arm = 1'b0;
						end else if (cal_arm && cal_timer < CAL_LIMIT
							&& arm_key == rx_byte[5:0]) begin
							next_cal_arm = 1'b0;
							next_cal_pend = 1'b1;
							next_cal_key = rx_byte[5:0];
							next_kind = RESP_ACK;
							next_state = ST_LOAD;
						end else begin
							next_cal_arm = 1'b1;
							next_arm_key = rx_byte[5:0];
							next_cal_timer = 25'h0;
						end
					end
				end
			end
			ST_LOAD: begin
				next_pos = 3'h0;
				next_state = ST_SEND;
				unique case (kind)
					RESP_DATA: begin
						next_resp[0] = key_signal[7:0];
						next_resp[1] = key_signal[15:8];
						next_resp[2] = key_reference[7:0];
						next_resp[3] = key_reference[15:8];
						next_resp[4] = normal_integrator_count;
						next_dlen = `DATA_LEN;
						next_with_crc = 1'b1;
					end
					RESP_STATUS: begin
						next_resp[0] = 8'h00;
						next_resp[0][`ST_GAIN_FAULT] = key_gain_fault_test;
						next_resp[0][`ST_DETECT] = key_detect;
						next_resp[0][`ST_BELOW_LIMIT] =
							key_below_lower_signal_limit;
						next_resp[0][`ST_CALIBRATING] = key_calibrating;
						next_resp[0][`ST_CAL_FAILED] = key_cal_failed;
						next_dlen = `ONE_LEN;
						next_with_crc = 1'b1;
					end
					RESP_ACK: begin
						next_resp[0] = ~cmd;
						next_dlen = `ONE_LEN;
						next_with_crc = 1'b0;
					end
				endcase
				next_tx_byte = next_resp[0];
			end
			ST_SEND: begin
				if (tx_take) begin
					if (pos == last_pos) begin
						next_state = ST_IDLE;
					end else begin
						next_pos = npos;
						if (pos < dlen) begin
							next_crc = crc_bus.next;
						end
						if (npos < dlen) begin
							next_tx_byte = resp[npos];
						end else if (npos == dlen) begin
							next_tx_byte = crc_bus.next[7:0];
						end else begin
							next_tx_byte = crc[15:8];
						end
					end
				end
			end
		endcase

		// Setup block intake; excess bytes are dropped
		if (setup_valid && !setup_full) begin
			next_nv_wr = 1'b1;
			next_nv_addr = setup_count;
			next_nv_data = setup_byte;
			next_setup_count = setup_count + 9'h1;
			if (setup_count + 9'h1 == `SETUP_LEN) begin
				next_setup_full = 1'b1;
				next_reload_pending = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			kind <= RESP_ACK;
			cmd <= 8'h00;
			resp <= '{default: 8'h00};
			dlen <= 3'h0;
			pos <= 3'h0;
			with_crc <= 1'b0;
			crc <= `CRC_INIT;
			tx_byte <= 8'h00;
			key_sel <= 6'h00;
			sleep_armed <= 1'b0;
			sleep_active <= 1'b0;
			wake_scan <= 1'b0;
			wake_sync <= 3'h0;
			wake_lvl <= 1'b0;
			cal_arm <= 1'b0;
			arm_key <= 6'h00;
			cal_timer <= 25'h0;
			cal_pend <= 1'b0;
			cal_key <= 6'h00;
			cal_start <= 1'b0;
			setup_count <= 9'h000;
			nv_wr <= 1'b0;
			nv_addr <= 9'h000;
			nv_data <= 8'h00;
			setup_full <= 1'b0;
			reload_pending <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			cmd <= next_cmd;
			resp <= next_resp;
			dlen <= next_dlen;
			pos <= next_pos;
			with_crc <= next_with_crc;
			crc <= next_crc;
			tx_byte <= next_tx_byte;
			key_sel <= next_key_sel;
			sleep_armed <= next_sleep_armed;
			sleep_active <= next_sleep_active;
			wake_scan <= next_wake_scan;
			wake_sync <= {wake_sync[1:0], wake_pin};
			wake_lvl <= next_wake_lvl;
			cal_arm <= next_cal_arm;
			arm_key <= next_arm_key;
			cal_timer <= next_cal_timer;
			cal_pend <= next_cal_pend;
			cal_key <= next_cal_key;
			cal_start <= next_cal_start;
			setup_count <= next_setup_count;
			nv_wr <= next_nv_wr;
			nv_addr <= next_nv_addr;
			nv_data <= next_nv_data;
			setup_full <= next_setup_full;
			reload_pending <= next_reload_pending;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_sleep_ack;
		rx_take && is_sleep |-> ##2 tx_valid && tx_byte == 8'hE9;
	endproperty
	a_sleep_ack: assert property (p_sleep_ack) else $error("bad sleep ack");
	property p_sleep_entry;
		$rose(sleep_active) |-> $past(sleep_enable_cfg && !key_activity
			&& scan_end && sleep_armed);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep");
	property p_wake;
		sleep_active && wake_rise |=> !sleep_active && wake_scan;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake scan");
	property p_cancel;
		rx_take && is_keyed |=> !sleep_armed && !sleep_active;
	endproperty
	a_cancel: assert property (p_cancel) else $error("sleep not cancelled");
	property p_data_order;
		rx_take && is_keyed && cls == `CLASS_DATA |-> ##2
			tx_byte == $past(key_signal[7:0]) ##1 tx_valid [*1];
	endproperty
	a_data_order: assert property (p_data_order) else $error("bad data byte");
	property p_status;
		rx_take && is_keyed && cls == `CLASS_STATUS |-> ##2
			tx_byte == {3'h0, $past(key_gain_fault_test), $past(key_detect),
			$past(key_below_lower_signal_limit), $past(key_calibrating),
			$past(key_cal_failed)};
	endproperty
	a_status: assert property (p_status) else $error("bad status byte");
	property p_cal_slot;
		cal_start |-> $past(slot_valid && slot_key == cal_key && cal_pend);
	endproperty
	a_cal_slot: assert property (p_cal_slot) else $error("cal out of slot");
	property p_cal_first;
		rx_take && cls == `CLASS_CAL && idx_ok && !cal_arm && !cal_pend
			|=> !cal_pend ##1 !tx_valid;
	endproperty
	a_cal_first: assert property (p_cal_first) else $error("single cal ran");
	property p_bad_index;
		rx_take && cls != `CLASS_NONE && !idx_ok |-> ##2 !tx_valid;
	endproperty
	a_bad_index: assert property (p_bad_index) else $error("bad index answered");
	property p_setup_cap;
		setup_full |=> !nv_wr && setup_count == `SETUP_LEN;
	endproperty
	a_setup_cap: assert property (p_setup_cap) else $error("setup overrun");
	property p_data_len;
		rx_take && is_keyed && cls == `CLASS_DATA |-> ##2 tx_valid && pos == 3'h0
			&& last_pos == 3'h6;
	endproperty
	a_data_len: assert property (p_data_len) else $error("bad data length");

	c_sleep: cover property (sleep_active ##[1:20] wake_scan);
	c_cal: cover property (cal_start);
	c_data_done: cover property (tx_take && pos == 3'h6);
	c_setup: cover property ($rose(setup_full));
endmodule

// ===== touch_host.sv
// Purpose: Host side model that sends command bytes and takes replies
// Assumes: Its tasks are entered just after a rising clock edge
// Notes: Released command lines show the inverse of the last byte
module touch_host (
	input wire logic core_clk,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	bit slow;
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		tx_ready = 1'b1;
		slow = 1'b0;
	end
	// Random stalls so every reply byte has to stand until taken
	always @(posedge core_clk) begin
		tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
	end
	task send(input logic [7:0] b);
		int n;
		@(posedge core_clk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rx_ready !== 1'b1 && n < 50);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
	endtask
	// Extra cycles after the last byte catch any stray reply byte
	task recv(input int cnt, output logic [7:0] q[$]);
		int n;
		q = {};
		n = 0;
		while (q.size() < cnt && n < 40 * cnt) begin
			@(posedge core_clk);
			n++;
			if (tx_valid === 1'b1 && tx_ready === 1'b1)
				q.push_back(tx_byte);
		end
		repeat (5) begin
			@(posedge core_clk);
			if (tx_valid === 1'b1)
				q.push_back(tx_byte);
		end
	endtask
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the touch key command handler
// Assumes: Short calibration window parameter for simulation
// Notes: Expected replies come from a bench model built on queues
`include "touch_key_map.svh"
module tb;
	import touch_key_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned WIN = 200;
	logic core_clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready;
	logic [7:0] rx_byte, tx_byte, normal_integrator_count;
	logic [15:0] key_signal, key_reference;
	logic key_gain_fault_test, key_detect, key_below_lower_signal_limit;
	logic key_calibrating, key_cal_failed, sleep_enable_cfg, key_activity;
	logic scan_end, wake_pin, sleep_active, wake_scan, run_mode;
	logic slot_valid, cal_start, setup_valid, nv_wr, setup_full;
	logic reload_pending, seen;
	logic [7:0] setup_byte, nv_data, b;
	logic [8:0] nv_addr;
	logic [4:0] v;
	key_idx_t key_sel, slot_key, cal_key;
	int failures, checks;
	logic [7:0] want[$];
	logic [7:0] got[$];

	touch_key_command_handler #(.CAL_WINDOW_CYC(WIN)) uut (
		.core_clk, .rst_n, .rx_valid, .rx_byte, .rx_ready, .tx_valid,
		.tx_byte, .tx_ready, .key_sel, .key_signal, .key_reference,
		.normal_integrator_count, .key_gain_fault_test, .key_detect,
		.key_below_lower_signal_limit, .key_calibrating, .key_cal_failed,
		.sleep_enable_cfg, .key_activity, .scan_end, .wake_pin,
		.sleep_active, .wake_scan, .run_mode, .slot_valid, .slot_key,
		.cal_start, .cal_key, .setup_valid, .setup_byte, .nv_wr,
		.nv_addr, .nv_data, .setup_full, .reload_pending
	);
	touch_host host (.core_clk, .rx_ready, .tx_valid, .tx_byte, .rx_valid,
		.rx_byte, .tx_ready);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task chk(input string what, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] d);
		c = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			c = c[15] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
		return c;
	endfunction
	task cmd(input logic [7:0] cb, input bit crc);
		logic [15:0] c;
		c = crc_add(`CRC_INIT, cb);
		foreach (want[i])
			c = crc_add(c, want[i]);
		if (crc)
			want = {want, c[7:0], c[15:8]};
		host.send(cb);
		host.recv(want.size(), got);
		chk("reply length", want.size(), got.size());
		foreach (want[i])
			if (i < got.size())
				chk("reply byte", want[i], got[i]);
		want = {};
	endtask
	task data_cmd(input logic [5:0] k);
		logic [15:0] s, r;
		logic [7:0] n;
		s = 16'($urandom);
		r = 16'($urandom);
		n = 8'($urandom);
		key_signal <= s;
		key_reference <= r;
		normal_integrator_count <= n;
		want = {s[7:0], s[15:8], r[7:0], r[15:8], n};
		cmd({2'b01, k}, 1'b1);
		chk("key select", k, key_sel);
	endtask
	task scan;
		scan_end <= 1'b1;
		@(posedge core_clk);
		scan_end <= 1'b0;
		ticks(3);
	endtask
	task slot(input logic [5:0] k, input logic e);
		slot_valid <= 1'b1;
		slot_key <= k;
		@(posedge core_clk);
		slot_valid <= 1'b0;
		slot_key <= ~k;
		seen = 1'b0;
		repeat (3) begin
			@(posedge core_clk);
			if (cal_start === 1'b1)
				seen = 1'b1;
		end
		chk("calibration start", e, seen);
		if (e)
			chk("calibration key", k, cal_key);
	endtask
	task conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Whole run needs well under twenty thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		conclude();
	end

	initial begin
		failures = 0;
		checks = 0;
		rst_n = 1'b0;
		{key_signal, key_reference, normal_integrator_count} = '0;
		{key_gain_fault_test, key_detect, key_below_lower_signal_limit} = '0;
		{key_calibrating, key_cal_failed, sleep_enable_cfg} = '0;
		{key_activity, scan_end, wake_pin, run_mode, slot_valid} = '0;
		slot_key = 6'h00;
		setup_valid = 1'b0;
		setup_byte = 8'h00;
		void'($urandom(33041));
		ticks(4);
		rst_n <= 1'b1;
		ticks(1);
		chk("ready after reset", 1, rx_ready);
		chk("reply idle after reset", 0, tx_valid);
		for (int i = 0; i < 4; i++) begin
			host.slow = i[0];
			data_cmd(i == 0 ? 6'h00 : i == 1 ? 6'h2F
				: 6'($urandom_range(47)));
		end
		for (int i = 0; i < 7; i++) begin
			host.slow = i[1];
			v = (i < 5) ? 5'(1 << i) : 5'($urandom);
			{key_gain_fault_test, key_detect, key_below_lower_signal_limit,
				key_calibrating, key_cal_failed} <= v;
			want = {8'({3'b000, v})};
			cmd({2'b10, 6'(i * 7)},
				1'b1);
		end
		host.slow = 1'b0;
		cmd(8'h70, 1'b0);
		cmd(8'hB0, 1'b0);
		cmd(8'hF0, 1'b0);
		sleep_enable_cfg <= 1'b1;
		key_activity <= 1'b1;
		want = {8'hE9};
		cmd(`CMD_SLEEP, 1'b0);
		scan();
		chk("asleep with activity", 0, sleep_active);
		key_activity <= 1'b0;
		scan();
		chk("asleep at scan end", 1, sleep_active);
		wake_pin <= 1'b1;
		seen = 1'b0;
		repeat (10) begin
			@(posedge core_clk);
			if (wake_scan === 1'b1)
				seen = 1'b1;
		end
		wake_pin <= 1'b0;
		chk("wake scan", 1, seen);
		chk("awake for scan", 0, sleep_active);
		scan();
		chk("back asleep", 1, sleep_active);
		data_cmd(6'h03);
		chk("woken by command", 0, sleep_active);
		scan();
		chk("sleep cancelled", 0, sleep_active);
		run_mode <= 1'b1;
		cmd(8'hC5, 1'b0);
		want = {8'h3A};
		cmd(8'hC5, 1'b0);
		slot(6'h04, 1'b0);
		slot(6'h05, 1'b1);
		cmd(8'hEF, 1'b0);
		want = {8'h10};
		cmd(8'hEF, 1'b0);
		slot(6'h2F, 1'b1);
		cmd(8'hC5, 1'b0);
		want = {8'hE9};
		cmd(`CMD_SLEEP, 1'b0);
		cmd(8'hC5, 1'b0);
		ticks(WIN + 50);
		cmd(8'hC5, 1'b0);
		want = {8'h3A};
		cmd(8'hC5, 1'b0);
		run_mode <= 1'b0;
		cmd(8'hCA, 1'b0);
		cmd(8'hCA, 1'b0);
		for (int i = 0; i < 351; i++) begin
			b = (i >= 60 && i < 300) ? 8'h00 : 8'($urandom);
			setup_valid <= 1'b1;
			setup_byte <= b;
			@(posedge core_clk);
			setup_valid <= 1'b0;
			@(posedge core_clk);
			chk("array write", i < 350, nv_wr);
			if (i < 350) begin
				chk("array address", i, nv_addr);
				chk("array data", b, nv_data);
			end
		end
		chk("setup full", 1, setup_full);
		chk("reload pending", 1, reload_pending);
		rst_n <= 1'b0;
		ticks(2);
		rst_n <= 1'b1;
		ticks(2);
		chk("reload after reset", 0, reload_pending);
		chk("full after reset", 0, setup_full);
		conclude();
	end
endmodule
